// ### core/cmpc_cfg.svh
// constants for the comparator output conditioner
`ifndef CMPC_CFG_SVH
`define CMPC_CFG_SVH
`define CMPC_AW            4
`define CMPC_DW            32
`define CMPC_ADDR_DIV1     4'h0
`define CMPC_ADDR_CR0_1    4'h1
`define CMPC_ADDR_CR1_1    4'h2
`define CMPC_ADDR_SR_1     4'h3
`define CMPC_ADDR_DIV2     4'h4
`define CMPC_ADDR_CR0_2    4'h5
`define CMPC_ADDR_CR1_2    4'h6
`define CMPC_ADDR_SR_2     4'h7
`define CMPC_DIV_RST       8'h00
`define CMPC_CR0_RST       16'h0000
`define CMPC_CR1_RST       16'h0000
// control zero fields
`define CMPC_C0_EN         0
`define CMPC_C0_IE         1
`define CMPC_C0_HYS_LO     2
`define CMPC_C0_HYS_HI     3
`define CMPC_C0_RESPONSE_SPEED_SELECT_LO    4
`define CMPC_C0_RESPONSE_SPEED_SELECT_HI    5
`define CMPC_C0_POL        6
`define CMPC_C0_WIN        7
// control one fields
`define CMPC_C1_FEN        0
`define CMPC_C1_FCLK       1
`define CMPC_C1_FW_LO      2
`define CMPC_C1_FW_HI      4
`define CMPC_C1_BL_LO      5
`define CMPC_C1_BL_HI      7
`define CMPC_C1_BKA        8
`define CMPC_C1_BKB        9
`define CMPC_C1_BKC        10
`define CMPC_C1_BRK        11
`define CMPC_C1_CLR        12
`define CMPC_C1_HIE        13
`define CMPC_C1_RIE        14
`define CMPC_C1_FIE        15
// status fields
`define CMPC_SR_INTERRUPT_FLAG       0
`define CMPC_SR_LVL        1
`define CMPC_SR_RDY        2
`define CMPC_BLANK_BASE    2
`define CMPC_BLANK_SLACK   10'h001
`define CMPC_CNT_W         10
`endif

// ### core/cmpc_pkg.sv
// types for the comparator output conditioner
package cmpc_pkg;
   typedef struct packed {
      logic       raw_compare_result;
      logic       comp_ready;
   } cmpc_ana_t;
   typedef struct packed {
      logic       brake;
      logic       refclear;
      logic       pin;
   } cmpc_route_t;
   typedef enum logic [1:0] {
      CMPC_IDLE  = 2'b00,
      CMPC_BLANK = 2'b01
   } cmpc_blank_t;
endpackage

// ### core/cmpc_top.sv
// comparator output conditioner: two channels of digital post-processing
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
`include "cmpc_cfg.svh"

// Function
// - output_invert set inverts raw result, clear passes it unchanged.
// - deglitch filter used only when deglitch_enable is one.
// - deglitch_clock_select one uses bus clock, zero the slow oscillator.
// - eight widths; pulses shorter than selected filter cycles are removed.
// - deglitched level readable in the status register.
// - output pin carries the filtered level, not the raw one.
// - brake and reference-clear outputs each gated by own control bit.
// - two-bit hysteresis setting held and presented to analog core.
// - window bit set gives XOR of both channels, else own result.
// - during blanking the output holds its level from window start.
// - blanking lasts 2^(n+2) to 2^(n+2)+2 bus clocks for code n.
// - blanking started by enabled rising edges of timer channels a-c.
// - after blanking the output tracks the comparator again.
// - interrupt asserted only when enable and flag are both one.
// - selected trigger event sets the interrupt flag.
// - writing zero to the flag clears it; a new event wins.
// - level trigger raises event while output is high.
// - up-edge trigger raises event on each low-to-high change.
// - down-edge trigger raises event on each high-to-low change.
// - trigger enables are independent; any enabled one sets the flag.
// - interrupt logic runs on bus clock only and holds while ce is low, so not usable for wake-up.
// - both divider addresses reach one shared register.
module cmpc_top
   import cmpc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    ce,
   input  wire logic                    osc_tick,
   input  wire logic [`CMPC_AW-1:0]     addr,
   input  wire logic [`CMPC_DW-1:0]     wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [`CMPC_DW-1:0]     rdata,
   input  wire cmpc_ana_t [1:0]         ana,
   input  wire logic [2:0]              timer_channel_comp,
   output logic      [1:0]              comp_enable,
   output logic      [1:0][1:0]         hysteresis_select,
   output logic      [1:0][1:0]         response_speed_select,
   output logic      [7:0]              divider_control,
   output cmpc_route_t [1:0]            route,
   output logic      [1:0]              irq
);

   logic [7:0]                divider_control_reg_r;
   logic [1:0][15:0]          ctl0_r;
   logic [1:0][15:0]          ctl1_r;
   logic [1:0]                interrupt_flag_r;
   logic [1:0]                deglitched_level_r;
   logic [1:0][`CMPC_CNT_W-1:0] flt_cnt_r;
   logic [1:0]                held_r;
   cmpc_blank_t [1:0]         blank_st_r;
   logic [1:0][`CMPC_CNT_W-1:0] blank_cnt_r;
   logic [1:0]                final_prev_r;
   logic [2:0]                chan_prev_r;
   logic [1:0]                polarity_adjusted_result;
   logic [1:0]                windowed_result;
   logic [1:0]                unfiltered;
   logic [1:0]                final_lvl;
   logic [1:0]                trig_evt;
   logic [1:0]                blank_start;
   logic [1:0]                flag_clr;
   logic [2:0]                chan_rise;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   // filter width code to cycles: 2^code, so code 0 is one cycle
   function automatic logic [`CMPC_CNT_W-1:0] flt_cycles(
      input logic [2:0] code);
      flt_cycles = `CMPC_CNT_W'(1) << code;
   endfunction

   // blanking length: base 2^(n+2), plus one for slack inside the range
   function automatic logic [`CMPC_CNT_W-1:0] blank_cycles(
      input logic [2:0] code);
      // four-bit shift amount, or codes 6 and 7 would wrap to short windows
      blank_cycles = (`CMPC_CNT_W'(1)
                      << ({1'b0, code} + 4'(`CMPC_BLANK_BASE)))
                     + `CMPC_BLANK_SLACK;
   endfunction

   // the divider is shared, so both indexes decode to it
   function automatic logic div_hit(
      input logic [`CMPC_AW-1:0] a);
      div_hit = (a == `CMPC_ADDR_DIV1) || (a == `CMPC_ADDR_DIV2);
   endfunction

   // status word of one channel, upper bits read zero
   function automatic logic [`CMPC_DW-1:0] status_word(
      input logic ready,
      input logic lvl,
      input logic flag);
      status_word                = '0;
      status_word[`CMPC_SR_RDY]  = ready;
      status_word[`CMPC_SR_LVL]  = lvl;
      status_word[`CMPC_SR_INTERRUPT_FLAG] = flag;
   endfunction

   // writing one to the flag bit leaves it alone
   function automatic logic clr_hit(
      input logic [`CMPC_AW-1:0] a,
      input logic [`CMPC_AW-1:0] sr_addr,
      input logic [`CMPC_DW-1:0] w);
      clr_hit = (a == sr_addr) && !w[`CMPC_SR_INTERRUPT_FLAG];
   endfunction

   // any enabled trigger condition raises the event
   function automatic logic trig_hit(
      input logic [15:0] c1,
      input logic        lvl,
      input logic        prev);
      trig_hit = (c1[`CMPC_C1_HIE] && lvl)
               | (c1[`CMPC_C1_RIE] && lvl && !prev)
               | (c1[`CMPC_C1_FIE] && !lvl && prev);
   endfunction

   // --------------------------------------------------------------
   // register bus
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         divider_control_reg_r <= `CMPC_DIV_RST;
      end else if (ce && wr && div_hit(addr)) begin
         divider_control_reg_r <= wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl0_r <= {2{`CMPC_CR0_RST}};
      end else if (ce && wr) begin
         if (addr == `CMPC_ADDR_CR0_1) begin
            ctl0_r[0] <= wdata[15:0];
         end else if (addr == `CMPC_ADDR_CR0_2) begin
            ctl0_r[1] <= wdata[15:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctl1_r <= {2{`CMPC_CR1_RST}};
      end else if (ce && wr) begin
         if (addr == `CMPC_ADDR_CR1_1) begin
            ctl1_r[0] <= wdata[15:0];
         end else if (addr == `CMPC_ADDR_CR1_2) begin
            ctl1_r[1] <= wdata[15:0];
         end
      end
   end

   always_comb begin
      flag_clr[0] = wr && clr_hit(addr, `CMPC_ADDR_SR_1, wdata);
      flag_clr[1] = wr && clr_hit(addr, `CMPC_ADDR_SR_2, wdata);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd) begin
            if (div_hit(addr)) begin
               rdata <= {24'h000000, divider_control_reg_r};
            end else if (addr == `CMPC_ADDR_CR0_1) begin
               rdata <= {16'h0000, ctl0_r[0]};
            end else if (addr == `CMPC_ADDR_CR1_1) begin
               rdata <= {16'h0000, ctl1_r[0]};
            end else if (addr == `CMPC_ADDR_SR_1) begin
               rdata <= status_word(ana[0].comp_ready,
                  deglitched_level_r[0], interrupt_flag_r[0]);
            end else if (addr == `CMPC_ADDR_CR0_2) begin
               rdata <= {16'h0000, ctl0_r[1]};
            end else if (addr == `CMPC_ADDR_CR1_2) begin
               rdata <= {16'h0000, ctl1_r[1]};
            end else if (addr == `CMPC_ADDR_SR_2) begin
               rdata <= status_word(ana[1].comp_ready,
                  deglitched_level_r[1], interrupt_flag_r[1]);
            end
         end
      end
   end

   // --------------------------------------------------------------
   // polarity, window, blanking
   // --------------------------------------------------------------
   // --------------------------------------------------------------
   // timer edge detect
   // --------------------------------------------------------------
   // computed apart so blank_start never reads a stale edge
   assign chan_rise = timer_channel_comp & ~chan_prev_r;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         polarity_adjusted_result[i] = ana[i].raw_compare_result
                                       ^ ctl0_r[i][`CMPC_C0_POL];
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         windowed_result[i] = ctl0_r[i][`CMPC_C0_WIN]
            ? (polarity_adjusted_result[0] ^ polarity_adjusted_result[1])
            : polarity_adjusted_result[i];
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         blank_start[i] =
            |(chan_rise & ctl1_r[i][`CMPC_C1_BKC:`CMPC_C1_BKA]);
         unfiltered[i] = (blank_st_r[i] == CMPC_BLANK) ? held_r[i]
                         : windowed_result[i];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chan_prev_r <= 3'h0;
      end else if (ce) begin
         chan_prev_r <= timer_channel_comp;
      end
   end

   // a retrigger during a window is ignored; the level stays frozen
   always_ff @(posedge clk) begin
      if (rst) begin
         blank_st_r  <= {2{CMPC_IDLE}};
         blank_cnt_r <= '0;
         held_r      <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            case (blank_st_r[i])
               CMPC_IDLE: begin
                  held_r[i] <= windowed_result[i];
                  if (blank_start[i]) begin
                     blank_st_r[i]  <= CMPC_BLANK;
                     blank_cnt_r[i] <= blank_cycles(
                        ctl1_r[i][`CMPC_C1_BL_HI:`CMPC_C1_BL_LO]);
                  end
               end
               CMPC_BLANK: begin
                  blank_cnt_r[i] <= blank_cnt_r[i] - `CMPC_CNT_W'(1);
                  if (blank_cnt_r[i] == `CMPC_CNT_W'(1)) begin
                     blank_st_r[i] <= CMPC_IDLE;
                  end
               end
               default: blank_st_r[i] <= CMPC_IDLE;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // deglitch filter
   // --------------------------------------------------------------
   // slow oscillator arrives as a one-cycle tick in the bus domain,
   // so its resolution is a whole bus clock
   always_ff @(posedge clk) begin
      if (rst) begin
         deglitched_level_r <= 2'h0;
         flt_cnt_r          <= '0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (!ctl1_r[i][`CMPC_C1_FEN]) begin
               deglitched_level_r[i] <= unfiltered[i];
               flt_cnt_r[i]          <= '0;
            end else if (unfiltered[i] == deglitched_level_r[i]) begin
               flt_cnt_r[i] <= '0;
            end else if (ctl1_r[i][`CMPC_C1_FCLK] || osc_tick) begin
               if (flt_cnt_r[i] + `CMPC_CNT_W'(1) >= flt_cycles(
                      ctl1_r[i][`CMPC_C1_FW_HI:`CMPC_C1_FW_LO])) begin
                  deglitched_level_r[i] <= unfiltered[i];
                  flt_cnt_r[i]          <= '0;
               end else begin
                  flt_cnt_r[i] <= flt_cnt_r[i] + `CMPC_CNT_W'(1);
               end
            end
         end
      end
   end

   assign final_lvl = deglitched_level_r;

   // --------------------------------------------------------------
   // interrupt triggers
   // --------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         trig_evt[i] = trig_hit(ctl1_r[i], final_lvl[i],
                                final_prev_r[i]);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         final_prev_r <= 2'h0;
      end else if (ce) begin
         final_prev_r <= final_lvl;
      end
   end

   // runs on the bus clock only, gated by ce like the rest, so it holds while ce is low
   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_flag_r <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (trig_evt[i]) begin
               interrupt_flag_r[i] <= 1'b1;
            end else if (flag_clr[i]) begin
               interrupt_flag_r[i] <= 1'b0;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // registered outputs
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            irq[i] <= ctl0_r[i][`CMPC_C0_IE]
                      && interrupt_flag_r[i];
         end
      end
   end

   // --------------------------------------------------------------
   // timer routing and pin
   // --------------------------------------------------------------
   // brake and clear follow the filtered level, never the raw one
   always_ff @(posedge clk) begin
      if (rst) begin
         route <= '0;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            route[i].pin      <= final_lvl[i];
            route[i].brake    <= ctl1_r[i][`CMPC_C1_BRK]
                                 && final_lvl[i];
            route[i].refclear <= ctl1_r[i][`CMPC_C1_CLR]
                                 && final_lvl[i];
         end
      end
   end

   // --------------------------------------------------------------
   // analog core controls
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         comp_enable           <= 2'h0;
         hysteresis_select     <= '0;
         response_speed_select <= '0;
         divider_control       <= `CMPC_DIV_RST;
      end else if (ce) begin
         divider_control <= divider_control_reg_r;
         for (int i = 0; i < 2; i++) begin
            comp_enable[i] <= ctl0_r[i][`CMPC_C0_EN];
            hysteresis_select[i] <=
               ctl0_r[i][`CMPC_C0_HYS_HI:`CMPC_C0_HYS_LO];
            response_speed_select[i] <=
               ctl0_r[i][`CMPC_C0_RESPONSE_SPEED_SELECT_HI:`CMPC_C0_RESPONSE_SPEED_SELECT_LO];
         end
      end
   end

endmodule

// ### bench/cmpc_ana_model.sv
// behavioural pair of analog comparator cores feeding the conditioner
`timescale 1ns/1ns
module cmpc_ana_model
   import cmpc_pkg::*;
#(
   parameter int READY_DLY = 3
)
(
   input  wire logic       clk,
   input  wire logic [1:0] enable,
   input  wire logic [1:0] target,
   output cmpc_ana_t [1:0] ana
);
   // --------------------------------
   // settling and result
   // --------------------------------
   int cnt [2] = '{0, 0};
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         cnt[i] <= !enable[i] ? 0
                   : (cnt[i] < READY_DLY ? cnt[i] + 1 : cnt[i]);
      end
   end
   // a disabled core gives no result, so it drives low
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ana[i].comp_ready = enable[i] && cnt[i] >= READY_DLY;
         ana[i].raw_compare_result = enable[i] ? target[i] : 1'b0;
      end
   end
endmodule

// ### bench/cmpc_top_sva.sv
// checker on the comparator conditioner ports
`timescale 1ns/1ns
`include "cmpc_cfg.svh"
module cmpc_top_sva
   import cmpc_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst,
   input wire logic [`CMPC_AW-1:0] addr,
   input wire logic [`CMPC_DW-1:0] wdata,
   input wire logic                wr,
   input wire logic                rd,
   input wire logic [`CMPC_DW-1:0] rdata,
   input wire cmpc_ana_t [1:0]     ana,
   input wire logic [1:0][1:0]     hysteresis_select,
   input wire logic [7:0]          divider_control,
   input wire cmpc_route_t [1:0]   route,
   input wire logic [1:0]          irq
);
   // --------------------------------
   // properties
   // --------------------------------
   // clock enable taken as high; frozen cycles are not modelled here
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   rdata_idle_a: assert property (!rd |=> rdata == '0)
      else $error("rdata not zero");
   unmapped_read_a: assert property (rd && addr[3] |=> rdata == '0)
      else $error("unmapped read not zero");
   hyst_copy_a: assert property (
      wr && addr == `CMPC_ADDR_CR0_1 |=> ##1
      hysteresis_select[0] == $past(wdata[3:2], 2))
      else $error("hysteresis copy wrong");
   div_share_a: assert property (
      wr && addr == `CMPC_ADDR_DIV2 |=> ##1
      divider_control == $past(wdata[7:0], 2))
      else $error("divider copy wrong");
   route_gate_a: assert property (
      route[0].brake || route[0].refclear |-> route[0].pin)
      else $error("route without level");
   level_pin_a: assert property (
      rd && addr == `CMPC_ADDR_SR_1 |=> rdata[1] == route[0].pin)
      else $error("status level differs from pin");
   level_pin_two_a: assert property (
      rd && addr == `CMPC_ADDR_SR_2 |=> rdata[1] == route[1].pin)
      else $error("status level differs from pin two");
   irq_gate_a: assert property (
      rd && addr == `CMPC_ADDR_SR_1 ##1 !rdata[0] |-> !irq[0])
      else $error("irq without flag");
   ready_live_a: assert property (
      rd && addr == `CMPC_ADDR_SR_2 |=> rdata[2] == $past(ana[1].comp_ready))
      else $error("ready bit wrong");
   irq_seen_c: cover property (irq[0]);
   brake_seen_c: cover property (route[0].brake);
   div_write_c: cover property (wr && addr == `CMPC_ADDR_DIV2);
endmodule
bind cmpc_top cmpc_top_sva cmpc_top_sva_inst (.clk, .rst, .addr, .wdata,
   .wr, .rd, .rdata, .ana, .hysteresis_select, .divider_control, .route,
   .irq);

// ### bench/comparator_output_conditioner_bench.sv
// self-checking bench for the comparator output conditioner
`timescale 1ns/1ns
`include "cmpc_cfg.svh"
`define CHK(n, e, s) begin \
   num_checks++; \
   if ((s) !== (e)) begin \
      failures++; \
      $display("[FAIL] %s exp %0h got %0h", n, e, s); \
   end \
end
module comparator_output_conditioner_bench
   import cmpc_pkg::*;
;
   logic             clk = 0, rst = 1, ce = 1, osc_tick = 0, osc_run = 0;
   logic             wr = 0, rd = 0;
   logic [3:0]       addr = '0;
   logic [31:0]      wdata = '0, rdata, d, v;
   logic [2:0]       timer_channel_comp = '0;
   logic [1:0]       raw = '0, comp_enable, irq;
   logic [1:0][1:0]  hysteresis_select, response_speed_select;
   logic [7:0]       divider_control;
   cmpc_ana_t [1:0]  ana;
   cmpc_route_t [1:0] route;
   int               failures = 0, num_checks = 0, cyc = 0, seed = 6399;
   cmpc_top cmpc_top_inst (.clk, .rst, .ce, .osc_tick, .addr, .wdata, .wr,
      .rd, .rdata, .ana, .timer_channel_comp, .comp_enable,
      .hysteresis_select, .response_speed_select, .divider_control,
      .route, .irq);
   cmpc_ana_model cmpc_ana_model_inst (.clk, .enable(comp_enable),
      .target(raw), .ana);
   always #50 clk = ~clk;
   // slow oscillator as a tick every other cycle while running
   always @(posedge clk) osc_tick <= osc_run & ~osc_tick;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] x);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= x;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] x);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      x = rdata;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   function automatic logic exp_lvl(int r0, int r1, int p0, int p1, int w);
      return w ? ((r0 ^ p0 ^ r1 ^ p1) & 1) : ((r0 ^ p0) & 1);
   endfunction
   // --------------------------------
   // stimulus
   // --------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 3; a++) begin
         rreg(a[3:0], d);
         `CHK("reset", 32'h0, d)
      end
      v = $random(seed) & 32'h0000_00FF;
      wreg(`CMPC_ADDR_DIV2, v);
      rreg(`CMPC_ADDR_DIV1, d);
      `CHK("div", v, d)
      `CHK("divc", v[7:0], divider_control)
      v = ($random(seed) & 32'h0000_003C) | 32'h1;
      wreg(`CMPC_ADDR_CR0_2, v);
      wreg(`CMPC_ADDR_CR0_1, 32'h1);
      rreg(`CMPC_ADDR_CR0_2, d);
      `CHK("ctl0", v, d)
      `CHK("hys", v[3:2], hysteresis_select[1])
      `CHK("response_speed_select", v[5:4], response_speed_select[1])
      wreg(4'h9, 32'hFFFF_FFFF);
      rreg(4'h9, d);
      `CHK("unmapped", 32'h0, d)
      wait_n(4);
      rreg(`CMPC_ADDR_SR_2, d);
      `CHK("ready", 1'b1, d[2])
      `CHK("en", 2'b11, comp_enable)
      for (int k = 0; k < 32; k++) begin
         v = $random(seed);
         wreg(`CMPC_ADDR_CR0_1, {24'h0, v[4], v[2], 6'h01});
         wreg(`CMPC_ADDR_CR0_2, {24'h0, v[4], v[3], 6'h01});
         raw <= v[1:0];
         wait_n(4);
         `CHK("pin1", exp_lvl(v[0], v[1], v[2], v[3], v[4]), route[0].pin)
         `CHK("pin2", exp_lvl(v[1], v[0], v[3], v[2], v[4]), route[1].pin)
         rreg(`CMPC_ADDR_SR_1, d);
         `CHK("level", exp_lvl(v[0], v[1], v[2], v[3], v[4]), d[1])
      end
      wreg(`CMPC_ADDR_CR0_1, 32'h1);
      wreg(`CMPC_ADDR_CR0_2, 32'h1);
      raw <= 2'b00;
      wreg(`CMPC_ADDR_CR1_1, 32'h0000_000B);
      wait_n(8);
      raw <= 2'b01;
      repeat (2) @(posedge clk);
      raw <= 2'b00;
      wait_n(8);
      `CHK("short", 1'b0, route[0].pin)
      raw <= 2'b01;
      wait_n(8);
      `CHK("long", 1'b1, route[0].pin)
      wreg(`CMPC_ADDR_CR1_1, 32'h0000_0009);
      raw <= 2'b00;
      wait_n(12);
      `CHK("osc_still", 1'b1, route[0].pin)
      osc_run = 1'b1;
      wait_n(16);
      `CHK("osc_run", 1'b0, route[0].pin)
      osc_run = 1'b0;
      // each trigger source in turn, blank code 1 gives 8 to 10 cycles
      for (int t = 0; t < 3; t++) begin
         wreg(`CMPC_ADDR_CR1_1, 32'h20 | (32'h100 << t));
         raw <= 2'b00;
         wait_n(6);
         timer_channel_comp <= 3'b001 << t;
         @(posedge clk);
         raw <= 2'b01;
         wait_n(5);
         `CHK("blank", 1'b0, route[0].pin)
         wait_n(10);
         `CHK("resume", 1'b1, route[0].pin)
         timer_channel_comp <= 3'b000;
      end
      for (int g = 0; g < 4; g++) begin
         wreg(`CMPC_ADDR_CR1_1, 32'(g) << 11);
         wait_n(3);
         `CHK("brake", g[0], route[0].brake)
         `CHK("clear", g[1], route[0].refclear)
      end
      wreg(`CMPC_ADDR_CR0_1, 32'h3);
      for (int m = 0; m < 3; m++) begin
         raw <= {1'b0, m == 2};
         wreg(`CMPC_ADDR_CR1_1, 32'h2000 << m);
         wait_n(4);
         wreg(`CMPC_ADDR_SR_1, 32'h0);
         wait_n(3);
         `CHK("idle", 1'b0, irq[0])
         raw <= {1'b0, m != 2};
         wait_n(6);
         `CHK("irq", 1'b1, irq[0])
         wreg(`CMPC_ADDR_SR_1, 32'h0);
         wait_n(3);
         `CHK("clr", m == 0, irq[0])
      end
      wreg(`CMPC_ADDR_CR1_1, 32'h2000);
      raw <= 2'b01;
      wreg(`CMPC_ADDR_CR0_1, 32'h1);
      wait_n(4);
      `CHK("mask", 1'b0, irq[0])
      rreg(`CMPC_ADDR_SR_1, d);
      `CHK("flag", 1'b1, d[0])
      end_of_test();
   end
endmodule
